// File: rtl/mcg_params.svh
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define MSR_CAPS_ADDR    32'h0000_0179
`define MSR_STATE_ADDR   32'h0000_017A
`define MSR_ENABLES_ADDR 32'h0000_017B
`define MSR_WDOG_ADDR    32'h0000_017C

// ----------------------------------------
// Fields
// ----------------------------------------
`define BANK_COUNT       8'h08
`define CAP_BANKEN_BIT   8
`define CAP_WDOG_BIT     9
`define CAP_BANKEN_VAL   1'b1
`define CAP_WDOG_VAL     1'b1
`define ST_RESTART_BIT   0
`define ST_CAUSE_BIT     1
`define ST_INPROG_BIT    2
`define WD_EN_BIT        0
`define WD_BASE_LSB      1
`define WD_BASE_MSB      2
`define WD_CS_LSB        3
`define WD_CS_MSB        6
`define WD_CFG_W         7
`define WD_BANK          6'h04

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ENABLES      64'h0000_0000_0000_0000
`define RST_WD_CFG       7'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS    8000
`define BASE_MS_NS       1000000
`define BASE_US_NS       1000
`define BASE_FAST_NS     5
`define NS_TO_CYC(ns)    (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// File: rtl/mcg_pkg.sv
package mcg_pkg;

  typedef enum logic [1:0] {
    BASE_MILLI,
    BASE_MICRO,
    BASE_FAST,
    BASE_RSVD
  } time_base_e;

  typedef enum logic {
    RUN_NORMAL,
    RUN_SHUTDOWN
  } run_state_e;

endpackage

// File: rtl/machine_check_global_watchdog.sv
// Contract
// [RULE_01] Capability low byte reports the number of error-reporting banks.
// [RULE_02] Capability bit 8 shows the bank-enable register is present.
// [RULE_03] Capability bit 9 shows the instruction watchdog is present.
// [RULE_04] Software never writes capabilities; bits 63 to 10 reserved.
// [RULE_05] State bit 0 set only when the program can resume reliably.
// [RULE_06] State bit 1 set when the saved instruction caused the error.
// [RULE_07] In-progress flag set on every machine-check exception.
// [RULE_08] Further error while in progress enters shutdown, no exception.
// [RULE_09] Handler software clears the in-progress flag when done.
// [RULE_10] Bank-enable register holds one bit per bank; all ones enables all.
// [RULE_11] Watchdog raises a machine check when no instruction completes.
// [RULE_12] Each completed instruction restarts the watchdog count.
// [RULE_13] Watchdog holds its count during halt or stop-grant.
// [RULE_14] Watchdog reporting is gated by its bank's control enables.
// [RULE_15] Config bit 0 enables counting; clear means no count, no check.
// [RULE_16] Bits 2:1 pick time base 1 ms, 1 us, 5 ns; 11b reserved. The 5 ns base rounds up to one 8 ns clock here.
// [RULE_17] Period equals selected count times selected time base.
// [RULE_18] Codes 0 to 7 give 4095 down to 31 units.
// [RULE_19] Code 8 gives 8191, code 9 gives 16383; rest reserved.
// [RULE_20] Software writes zeros to config bits 63 to 7.
// [RULE_21] Error registers survive a warm reset.
// [RULE_22] Uncorrectable errors raise the exception only when enabled.
// [RULE_23] Time-base ticks come from a prescaler with parameter ratios.
// [RULE_24] Reserved time base or count code never signals expiry.
`timescale 1ns/1ps
`include "mcg_params.svh"

module machine_check_global_watchdog
  import mcg_pkg::*;
#(
  parameter int unsigned BASE_MS_CYCLES   = `NS_TO_CYC(`BASE_MS_NS),
  parameter int unsigned BASE_US_CYCLES   = `NS_TO_CYC(`BASE_US_NS),
  parameter int unsigned BASE_FAST_CYCLES = `NS_TO_CYC(`BASE_FAST_NS)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        warm_rst_b,
  input  wire logic        msr_req,
  input  wire logic        msr_we,
  input  wire logic [31:0] msr_addr,
  input  wire logic [63:0] msr_wdata,
  output logic      [63:0] msr_rdata,
  output logic             msr_ack,
  output logic             msr_fault,
  input  wire logic        instr_retire,
  input  wire logic        core_halted,
  input  wire logic        core_stop_grant,
  input  wire logic        exception_enable_ctl,
  input  wire logic        wdog_bank_enable,
  input  wire logic        err_valid,
  input  wire logic [7:0]  err_bank,
  input  wire logic        err_uncorrectable,
  input  wire logic        err_restart_ok,
  input  wire logic        err_ip_is_cause,
  output logic             hardware_error_exception,
  output logic             shutdown,
  output logic             wdog_expire,
  output logic             check_in_progress
);

  // ----------------------------------------
  // Reset and warm-reset synchronisers
  // ----------------------------------------
  logic [1:0] rst_pipe_q;
  logic       rst_sync_b;
  logic       warm_meta_q;
  logic       warm_sync_q;
  logic       warm_act;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe_q[1];

  // Warm reset idles as released (high) after cold reset
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      warm_meta_q <= 1'b1;
      warm_sync_q <= 1'b1;
    end else begin
      warm_meta_q <= warm_rst_b;
      warm_sync_q <= warm_meta_q;
    end
  end
  assign warm_act = ~warm_sync_q;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic [63:0]          bank_en_q;
  logic [63:0]          bank_en_d;
  logic [`WD_CFG_W-1:0] wd_cfg_q;
  logic [`WD_CFG_W-1:0] wd_cfg_d;
  logic [63:0]          rdata_q;
  logic [63:0]          rdata_d;
  logic                 ack_q;
  logic                 ack_d;
  logic                 fault_q;
  logic                 fault_d;
  logic                 wr_state;
  logic                 wr_cfg;
  logic                 restart_ok_q;
  logic                 ip_cause_q;
  logic                 in_prog_q;
  logic [63:0]          bank_mask;

  // Banks above the implemented count read as zero
  assign bank_mask = (64'h0000_0000_0000_0001 << `BANK_COUNT)
                     - 64'h0000_0000_0000_0001;

  always_comb begin
    bank_en_d = bank_en_q;
    wd_cfg_d  = wd_cfg_q;
    rdata_d   = rdata_q;
    ack_d     = msr_req;
    fault_d   = 1'b0;
    wr_state  = 1'b0;
    wr_cfg    = 1'b0;
    if (msr_req) begin
      if (msr_addr == `MSR_CAPS_ADDR) begin
        // Writes are dropped; value is fixed by build
        if (!msr_we) begin
          rdata_d = 64'h0000_0000_0000_0000;
          rdata_d[7:0] = `BANK_COUNT; // [RULE_01]
          rdata_d[`CAP_BANKEN_BIT] = `CAP_BANKEN_VAL; // [RULE_02]
          rdata_d[`CAP_WDOG_BIT] = `CAP_WDOG_VAL; // [RULE_03]
        end
      end else if (msr_addr == `MSR_STATE_ADDR) begin
        wr_state = msr_we;
        if (!msr_we) begin
          rdata_d = 64'h0000_0000_0000_0000;
          rdata_d[`ST_RESTART_BIT] = restart_ok_q;
          rdata_d[`ST_CAUSE_BIT]   = ip_cause_q;
          rdata_d[`ST_INPROG_BIT]  = in_prog_q;
        end
      end else if (msr_addr == `MSR_ENABLES_ADDR) begin
        if (msr_we) begin
          bank_en_d = msr_wdata & bank_mask; // [RULE_10]
        end else begin
          rdata_d = bank_en_q;
        end
      end else if (msr_addr == `MSR_WDOG_ADDR) begin
        wr_cfg = msr_we;
        if (msr_we) begin
          // Upper bits are not stored
          wd_cfg_d = msr_wdata[`WD_CFG_W-1:0]; // [RULE_20]
        end else begin
          rdata_d = {57'h0, wd_cfg_q};
        end
      end else begin
        fault_d = 1'b1;
        rdata_d = 64'h0000_0000_0000_0000;
      end
    end
    if (warm_act) begin
      wd_cfg_d = `RST_WD_CFG;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bank_en_q <= `RST_ENABLES;
      wd_cfg_q  <= `RST_WD_CFG;
      rdata_q   <= 64'h0000_0000_0000_0000;
      ack_q     <= 1'b0;
      fault_q   <= 1'b0;
    end else begin
      bank_en_q <= bank_en_d;
      wd_cfg_q  <= wd_cfg_d;
      rdata_q   <= rdata_d;
      ack_q     <= ack_d;
      fault_q   <= fault_d;
    end
  end

  // ----------------------------------------
  // Instruction watchdog
  // ----------------------------------------
  time_base_e  base_sel;
  logic [3:0]  cs_sel;
  logic [14:0] unit_lim;
  logic        lim_ok;
  logic [16:0] ratio_m1;
  logic        run_ok;
  logic [16:0] pre_q;
  logic [16:0] pre_d;
  logic [14:0] unit_q;
  logic [14:0] unit_d;
  logic        expire_q;
  logic        expire_d;

  assign base_sel = time_base_e'(wd_cfg_q[`WD_BASE_MSB:`WD_BASE_LSB]);
  assign cs_sel = wd_cfg_q[`WD_CS_MSB:`WD_CS_LSB];

  always_comb begin
    lim_ok = (cs_sel <= 4'h9); // [RULE_24]
    case (cs_sel) // [RULE_18] [RULE_19]
      4'h0: unit_lim = 15'd4095;
      4'h1: unit_lim = 15'd2047;
      4'h2: unit_lim = 15'd1023;
      4'h3: unit_lim = 15'd511;
      4'h4: unit_lim = 15'd255;
      4'h5: unit_lim = 15'd127;
      4'h6: unit_lim = 15'd63;
      4'h7: unit_lim = 15'd31;
      4'h8: unit_lim = 15'd8191;
      4'h9: unit_lim = 15'd16383;
      default: unit_lim = 15'd1;
    endcase
    case (base_sel) // [RULE_16] [RULE_23]
      BASE_MILLI: ratio_m1 = 17'(BASE_MS_CYCLES - 1);
      BASE_MICRO: ratio_m1 = 17'(BASE_US_CYCLES - 1);
      BASE_FAST:  ratio_m1 = 17'(BASE_FAST_CYCLES - 1);
      default:    ratio_m1 = 17'h0_0000;
    endcase
  end

  // Reserved codes park the counter rather than guess a period
  assign run_ok = wd_cfg_q[`WD_EN_BIT] && lim_ok
                  && (base_sel != BASE_RSVD); // [RULE_15] [RULE_24]

  always_comb begin
    pre_d    = pre_q;
    unit_d   = unit_q;
    expire_d = 1'b0;
    if (warm_act || !run_ok || wr_cfg || instr_retire) begin // [RULE_12]
      pre_d  = 17'h0_0000;
      unit_d = 15'h0000;
    end else if (core_halted || core_stop_grant) begin
      pre_d  = pre_q; // [RULE_13]
    end else if (pre_q >= ratio_m1) begin
      pre_d = 17'h0_0000;
      if (unit_q + 15'd1 >= unit_lim) begin
        unit_d   = 15'h0000; // [RULE_17]
        expire_d = 1'b1; // [RULE_11]
      end else begin
        unit_d = unit_q + 15'd1;
      end
    end else begin
      pre_d = pre_q + 17'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pre_q    <= 17'h0_0000;
      unit_q   <= 15'h0000;
      expire_q <= 1'b0;
    end else begin
      pre_q    <= pre_d;
      unit_q   <= unit_d;
      expire_q <= expire_d;
    end
  end

  // ----------------------------------------
  // Exception and shutdown control
  // ----------------------------------------
  run_state_e run_q;
  run_state_e run_d;
  logic       restart_ok_d;
  logic       ip_cause_d;
  logic       in_prog_d;
  logic       exc_q;
  logic       exc_d;
  logic       ext_rep;
  logic       wd_rep;

  // Correctable errors stay in the bank logs only
  assign ext_rep = err_valid && err_uncorrectable && exception_enable_ctl
                   && (err_bank < `BANK_COUNT)
                   && bank_en_q[err_bank[5:0]]; // [RULE_22]
  assign wd_rep  = expire_q && wdog_bank_enable && exception_enable_ctl
                   && bank_en_q[`WD_BANK]; // [RULE_14]

  always_comb begin
    run_d  = run_q;
    restart_ok_d = restart_ok_q;
    ip_cause_d   = ip_cause_q;
    in_prog_d    = in_prog_q;
    exc_d        = 1'b0;
    if (wr_state) begin
      restart_ok_d = msr_wdata[`ST_RESTART_BIT];
      ip_cause_d   = msr_wdata[`ST_CAUSE_BIT];
      in_prog_d    = msr_wdata[`ST_INPROG_BIT]; // [RULE_09]
    end
    case (run_q)
      RUN_NORMAL: begin
        if (ext_rep || wd_rep) begin
          if (in_prog_q) begin
            run_d = RUN_SHUTDOWN; // [RULE_08]
          end else begin
            exc_d     = 1'b1;
            in_prog_d = 1'b1; // [RULE_07]
            // A hung instruction cannot be resumed
            restart_ok_d = ext_rep ? err_restart_ok : 1'b0; // [RULE_05]
            ip_cause_d   = ext_rep ? err_ip_is_cause : 1'b1; // [RULE_06]
          end
        end
      end
      RUN_SHUTDOWN: run_d = RUN_SHUTDOWN;
    endcase
    // Logged state is kept; the core run state restarts, and the watchdog config and count clear too
    if (warm_act) begin
      run_d = RUN_NORMAL; // [RULE_21]
      exc_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      run_q  <= RUN_NORMAL;
      restart_ok_q <= 1'b0;
      ip_cause_q   <= 1'b0;
      in_prog_q    <= 1'b0;
      exc_q  <= 1'b0;
    end else begin
      run_q  <= run_d;
      restart_ok_q <= restart_ok_d;
      ip_cause_q   <= ip_cause_d;
      in_prog_q    <= in_prog_d;
      exc_q  <= exc_d;
    end
  end

  assign msr_rdata                = rdata_q;
  assign msr_ack                  = ack_q;
  assign msr_fault                = fault_q;
  assign hardware_error_exception = exc_q;
  assign shutdown                 = (run_q == RUN_SHUTDOWN);
  assign wdog_expire              = expire_q;
  assign check_in_progress        = in_prog_q;

endmodule

// File: bench/machine_check_global_watchdog_properties.sv
`timescale 1ns/1ps
`include "mcg_params.svh"

module machine_check_global_watchdog_properties (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        msr_req,
  input wire logic        msr_we,
  input wire logic [31:0] msr_addr,
  input wire logic [63:0] msr_rdata,
  input wire logic        msr_ack,
  input wire logic        msr_fault,
  input wire logic        exception_enable_ctl,
  input wire logic        hardware_error_exception,
  input wire logic        shutdown,
  input wire logic        check_in_progress
);
  // ----------------------------------------
  // Register port and exception checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic bad_addr;
  logic st_wr;
  assign bad_addr = msr_addr < `MSR_CAPS_ADDR || msr_addr > `MSR_WDOG_ADDR;
  assign st_wr = msr_req && msr_we && msr_addr == `MSR_STATE_ADDR;

  property p_ack; msr_ack == $past(msr_req); endproperty
  a_ack: assert property (p_ack)
    else $error("ack not one cycle after request");
  property p_fault_bad; msr_req && bad_addr |=> msr_fault && msr_rdata == 0;
  endproperty
  a_fault_bad: assert property (p_fault_bad)
    else $error("unmapped access not faulted");
  property p_fault_ok; msr_req && !bad_addr |=> !msr_fault; endproperty
  a_fault_ok: assert property (p_fault_ok)
    else $error("mapped access faulted");
  property p_caps; msr_req && !msr_we && msr_addr == `MSR_CAPS_ADDR
    |=> msr_rdata == {54'h0, 2'b11, `BANK_COUNT}; endproperty
  a_caps: assert property (p_caps)
    else $error("capability value wrong");
  property p_exc_flag; hardware_error_exception |-> check_in_progress;
  endproperty
  a_exc_flag: assert property (p_exc_flag)
    else $error("exception without in-progress flag");
  property p_exc_en; hardware_error_exception |-> $past(exception_enable_ctl);
  endproperty
  a_exc_en: assert property (p_exc_en)
    else $error("exception while disabled");
  property p_flag_hold; check_in_progress && !st_wr |=> check_in_progress;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("in-progress flag lost");
  property p_shut_cause; $rose(shutdown) |-> $past(check_in_progress);
  endproperty
  a_shut_cause: assert property (p_shut_cause)
    else $error("shutdown without flag");
  property p_shut_noexc; shutdown |-> !hardware_error_exception; endproperty
  a_shut_noexc: assert property (p_shut_noexc)
    else $error("exception in shutdown");
  c_exc: cover property (hardware_error_exception);
  c_shut: cover property ($rose(shutdown));
  c_fault: cover property (msr_fault);
endmodule

// File: bench/machine_check_global_watchdog_test.sv
`timescale 1ns/1ps
`include "mcg_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, g, e); end end

module machine_check_global_watchdog_test;
  import mcg_pkg::*;
  typedef struct {logic we; logic [31:0] a; logic [63:0] v; logic f;} row_s;
  logic        clk_sys = 0, rst_b = 0, warm_rst_b = 1;
  logic        msr_req = 0, msr_we = 0, msr_ack, msr_fault;
  logic [31:0] msr_addr = 0;
  logic [63:0] msr_wdata = 0, msr_rdata;
  logic        instr_retire = 0, core_halted = 0, core_stop_grant = 0;
  logic        exception_enable_ctl = 0, wdog_bank_enable = 0;
  logic        err_valid = 0, err_uncorrectable = 0;
  logic        err_restart_ok = 0, err_ip_is_cause = 0;
  logic [7:0]  err_bank = 0;
  logic        hardware_error_exception, shutdown, wdog_expire;
  logic        check_in_progress;
  logic        flt;
  int          errors = 0, cmp_count = 0, n;
  int          lim[10] = '{4095, 2047, 1023, 511, 255, 127, 63, 31, 8191,
                           16383};
  row_s        rows[12] = '{
    '{0, `MSR_STATE_ADDR, 64'h0, 0}, '{0, `MSR_ENABLES_ADDR, 64'h0, 0},
    '{0, `MSR_WDOG_ADDR, 64'h0, 0}, '{0, `MSR_CAPS_ADDR, 64'h308, 0},
    '{1, `MSR_CAPS_ADDR, '1, 0}, '{0, `MSR_CAPS_ADDR, 64'h308, 0},
    '{1, `MSR_ENABLES_ADDR, '1, 0}, '{0, `MSR_ENABLES_ADDR, 64'hff, 0},
    '{1, `MSR_WDOG_ADDR, ~64'h1, 0}, '{0, `MSR_WDOG_ADDR, 64'h7e, 0},
    '{0, 32'h0000_0400, 64'h0, 1}, '{1, 32'h0000_0000, 64'h0, 1}};

  machine_check_global_watchdog #(
    .BASE_MS_CYCLES(20), .BASE_US_CYCLES(4), .BASE_FAST_CYCLES(1)
  ) u_dut (
    .clk_sys, .rst_b, .warm_rst_b, .msr_req, .msr_we, .msr_addr, .msr_wdata,
    .msr_rdata, .msr_ack, .msr_fault, .instr_retire, .core_halted,
    .core_stop_grant, .exception_enable_ctl, .wdog_bank_enable, .err_valid,
    .err_bank, .err_uncorrectable, .err_restart_ok, .err_ip_is_cause,
    .hardware_error_exception, .shutdown, .wdog_expire, .check_in_progress
  );

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [63:0] d);
    @(negedge clk_sys);
    {msr_req, msr_we, msr_addr, msr_wdata} = {1'b1, w, a, d};
    // Answer stands one cycle only, so take it here
    @(negedge clk_sys);
    flt = msr_fault;
    `CHK(msr_ack, 1'b1)
    msr_req = 0;
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(negedge clk_sys);
      `CHK(wdog_expire, 1'b0)
    end
  endtask

  // Cycle index since the task call, bounded
  task automatic to_expire();
    n = 1;
    while (wdog_expire !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task automatic err(input logic [2:0] f);
    @(negedge clk_sys);
    {err_valid, err_uncorrectable, err_restart_ok, err_ip_is_cause} = {1'b1, f};
    @(negedge clk_sys);
    err_valid = 0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #400_000;
    errors++;
    final_report();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_b = 1;
    repeat (3) @(negedge clk_sys);
    foreach (rows[i]) begin
      acc(rows[i].we, rows[i].a, rows[i].v);
      `CHK(flt, rows[i].f)
      if (!rows[i].we) `CHK(msr_rdata, rows[i].v)
    end
    for (int cs = 0; cs < 10; cs++) begin
      acc(1, `MSR_WDOG_ADDR, {57'h0, cs[3:0], 3'b101});
      to_expire();
      `CHK(n, lim[cs] + 1)
    end
    for (int base = 0; base < 2; base++) begin
      acc(1, `MSR_WDOG_ADDR, {57'h0, 4'h7, base[1:0], 1'b1});
      to_expire();
      `CHK(n, (base ? 4 : 20) * 31 + 1)
    end
    // Disabled, reserved base, reserved count
    foreach (rows[i]) if (i < 3) begin
      acc(1, `MSR_WDOG_ADDR, i == 0 ? 64'h3c : (i == 1 ? 64'h3f : 64'h55));
      quiet(100);
    end
    acc(1, `MSR_WDOG_ADDR, 64'h3d);
    repeat (5) begin
      quiet(20);
      instr_retire = 1;
      quiet(1);
      instr_retire = 0;
    end
    core_halted = 1;
    quiet(100);
    {core_halted, core_stop_grant} = 2'b01;
    quiet(100);
    core_stop_grant = 0;
    to_expire();
    `CHK(n, 32)
    exception_enable_ctl = 1;
    to_expire();
    @(negedge clk_sys);
    `CHK(hardware_error_exception, 1'b0)
    wdog_bank_enable = 1;
    to_expire();
    @(negedge clk_sys);
    `CHK(hardware_error_exception, 1'b1)
    `CHK(check_in_progress, 1'b1)
    acc(1, `MSR_WDOG_ADDR, 64'h0);
    acc(0, `MSR_STATE_ADDR, 64'h0);
    `CHK(msr_rdata, 64'h6)
    acc(1, `MSR_STATE_ADDR, 64'h0);
    acc(1, `MSR_ENABLES_ADDR, 64'hfe);
    err(3'b111);
    `CHK(hardware_error_exception, 1'b0)
    acc(1, `MSR_ENABLES_ADDR, 64'hff);
    err(3'b011);
    `CHK(hardware_error_exception, 1'b0)
    exception_enable_ctl = 0;
    err(3'b111);
    `CHK(hardware_error_exception, 1'b0)
    exception_enable_ctl = 1;
    err(3'b110);
    `CHK(hardware_error_exception, 1'b1)
    acc(0, `MSR_STATE_ADDR, 64'h0);
    `CHK(msr_rdata, 64'h5)
    err(3'b111);
    `CHK(hardware_error_exception, 1'b0)
    `CHK(shutdown, 1'b1)
    warm_rst_b = 0;
    repeat (4) @(negedge clk_sys);
    warm_rst_b = 1;
    repeat (4) @(negedge clk_sys);
    `CHK(shutdown, 1'b0)
    acc(0, `MSR_STATE_ADDR, 64'h0);
    `CHK(msr_rdata, 64'h5)
    acc(0, `MSR_ENABLES_ADDR, 64'h0);
    `CHK(msr_rdata, 64'hff)
    final_report();
  end
endmodule

bind machine_check_global_watchdog machine_check_global_watchdog_properties
  u_props (.clk_sys(clk_sys), .rst_b(rst_b), .msr_req(msr_req),
  .msr_we(msr_we), .msr_addr(msr_addr), .msr_rdata(msr_rdata),
  .msr_ack(msr_ack), .msr_fault(msr_fault),
  .exception_enable_ctl(exception_enable_ctl),
  .hardware_error_exception(hardware_error_exception),
  .shutdown(shutdown), .check_in_progress(check_in_progress));
